// [logic/hmrs_defs.vh]
// Purpose: constants for the halt and reset source controller
// Assumes: 40 MHz pclk, apb word registers
// Notes:   byte offsets are multiples of four
`ifndef HMRS_DEFS_VH
`define HMRS_DEFS_VH
// ==================================================
// register offsets
`define HMRS_OFF_CTRL     8'h00
`define HMRS_OFF_OPT      8'h04
`define HMRS_OFF_STAT     8'h08
`define HMRS_OFF_MASK     8'h0c
`define HMRS_OFF_STATE    8'h10
// ==================================================
// ctrl fields
`define HMRS_CTRL_AWU     0
`define HMRS_CTRL_AHALT   1
`define HMRS_CTRL_WDOG    2
// opt fields
`define HMRS_OPT_LVDEN    0
`define HMRS_OPT_WDGH     1
`define HMRS_OPT_THR_LO   2
`define HMRS_OPT_THR_HI   3
`define HMRS_OPT_RST      4'h0
// status bits
`define HMRS_ST_HALT      0
`define HMRS_ST_WAKE      1
`define HMRS_ST_WDOG      2
`define HMRS_ST_LVD       3
`define HMRS_ST_ILL       4
`define HMRS_ST_W         5
// ==================================================
// timing
`define HMRS_STAB_CYC     9'd256
// minimum pin pulse: 500 ns at 25 ns per pclk, sized to the counter
`define HMRS_RSTOUT_CYC   9'd20
`define HMRS_CNT_W        9
`define HMRS_ZERO9        9'h000
`define HMRS_ONE9         9'h001
`endif

// [logic/hmrs_ctrl.v]
// Purpose: halt mode control and digital reset sources with apb registers
// Assumes: cpu core gives halt and decode strobes; one clock domain
// Notes:   reset pin is open drain, three signals
//
// Contract
// RL1: halt on instruction when awake modes off
// RL2: leave halt on reset or wake interrupt
// RL3: restart oscillator, hold cpu 256 cycles
// RL4: resume via interrupt or reset vector
// RL5: force interrupt mask clear on entry
// RL6: pending interrupt wakes at once
// RL7: oscillator off stops internal clocks
// RL8: watchdog option turns halt into reset
// RL9: watchdog underflow drives pin low minimum
// RL10: voltage detector reset holds pin low
// RL11: illegal opcode or prebyte raises reset
// RL12: option byte enables voltage detector reset
// RL13: option byte picks three thresholds
// RL14: wake service pushes, masks, restores code register
// RL15: auto wakeup mode wakes on own interrupts
// RL16: external circuit holds reset when detector off
// RL17: synchronise external reset before use
`include "hmrs_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module hmrs_ctrl (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        halt_instr,
    input  wire        wake_irq,
    input  wire        awu_irq,
    input  wire        irq_pending,
    input  wire        illegal_opcode,
    input  wire        illegal_prebyte,
    input  wire        wdog_underflow,
    input  wire        lvd_below,
    input  wire        rst_pin_in,
    output reg         rst_pin_out,
    output reg         rst_pin_oe,
    output reg         osc_on,
    output reg         cpu_hold,
    output reg         fetch_reset_vector,
    output reg         service_wake_irq,
    output reg         clear_imask,
    output reg  [1:0]  lvd_threshold,
    output reg         sys_rst_n,
    output reg         irq
);
    // ==================================================
    // states
    localparam [3:0] S_RUN  = 4'b0001;
    localparam [3:0] S_HALT = 4'b0010;
    localparam [3:0] S_STAB = 4'b0100;
    localparam [3:0] S_RES  = 4'b1000;

    reg [3:0]             state_reg;
    reg [3:0]             state_next;
    reg [`HMRS_CNT_W-1:0] stab_reg;
    reg [`HMRS_CNT_W-1:0] rpulse_reg;
    reg                   cause_rst_reg;
    reg [2:0]             ctrl_reg;
    reg [3:0]             opt_reg;
    reg [`HMRS_ST_W-1:0]  stat_reg;
    reg [`HMRS_ST_W-1:0]  mask_reg;
    reg                   ext_s1_reg;
    reg                   ext_s2_reg;

    // ==================================================
    // apb decode
    wire acc     = psel & penable;
    wire wr      = acc & pwrite;
    wire rd      = acc & ~pwrite;
    wire hit_ok  = (paddr == `HMRS_OFF_CTRL) | (paddr == `HMRS_OFF_OPT) |
                   (paddr == `HMRS_OFF_STAT) | (paddr == `HMRS_OFF_MASK) |
                   (paddr == `HMRS_OFF_STATE);

    // ==================================================
    // reset sources
    // RL12: option gates detector
    wire lvd_rst  = opt_reg[`HMRS_OPT_LVDEN] & lvd_below;
    // RL11: decode faults reset
    wire ill_rst  = illegal_opcode | illegal_prebyte;
    // RL8: halt under watchdog
    wire halt_req = halt_instr & (state_reg == S_RUN);
    wire wdg_halt = halt_req & ctrl_reg[`HMRS_CTRL_WDOG] & ~opt_reg[`HMRS_OPT_WDGH];
    wire wdg_rst  = wdog_underflow | wdg_halt;
    // RL17: synchronised external reset
    wire ext_rst  = ~ext_s2_reg;
    // RL15: auto wakeup mode adds own interrupt
    wire wake_src = wake_irq | (ctrl_reg[`HMRS_CTRL_AWU] & awu_irq);
    wire int_rst  = wdg_rst | ill_rst | lvd_rst | (rpulse_reg != `HMRS_ZERO9);

    // RL17: two flop synchroniser
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
        end else begin
            ext_s1_reg <= rst_pin_in;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // ==================================================
    // next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_RUN: begin
                // RL1: halt entry
                if (halt_req & ~wdg_halt & ~ctrl_reg[`HMRS_CTRL_AHALT] &
                    ~ctrl_reg[`HMRS_CTRL_AWU]) begin
                    // RL6: pending wakes at once
                    state_next = irq_pending ? S_STAB : S_HALT;
                end else if (halt_req & ctrl_reg[`HMRS_CTRL_AWU] & ~wdg_halt) begin
                    // RL15: auto wakeup halt
                    state_next = irq_pending ? S_STAB : S_HALT;
                end
            end
            S_HALT: begin
                // RL2: restricted wake sources
                if (wake_src)
                    state_next = S_STAB;
            end
            S_STAB: begin
                // RL3: stabilisation done
                if (stab_reg == `HMRS_ONE9)
                    state_next = S_RUN;
            end
            S_RES:   state_next = S_STAB;
            default: state_next = S_RUN;
        endcase
        if (int_rst | ext_rst)
            state_next = S_RES;
    end

    // ==================================================
    // state, counters, outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg          <= S_RES;
            stab_reg           <= `HMRS_ZERO9;
            rpulse_reg         <= `HMRS_ZERO9;
            cause_rst_reg      <= 1'b1;
            osc_on             <= 1'b1;
            cpu_hold           <= 1'b1;
            fetch_reset_vector <= 1'b0;
            service_wake_irq   <= 1'b0;
            clear_imask        <= 1'b0;
            sys_rst_n          <= 1'b0;
            rst_pin_out        <= 1'b0;
            rst_pin_oe         <= 1'b0;
        end else begin
            state_reg          <= state_next;
            fetch_reset_vector <= 1'b0;
            service_wake_irq   <= 1'b0;
            // RL5: clear mask on entry
            clear_imask        <= (state_reg == S_RUN) & (state_next != S_RUN) &
                                  ~(int_rst | ext_rst);
            // RL7: oscillator off while halted
            osc_on             <= (state_next != S_HALT);
            cpu_hold           <= (state_next != S_RUN);
            sys_rst_n          <= ~(state_next == S_RES);
            // RL9: minimum output pulse
            if (wdg_rst)
                rpulse_reg <= `HMRS_RSTOUT_CYC;
            else if (rpulse_reg != `HMRS_ZERO9)
                rpulse_reg <= rpulse_reg - `HMRS_ONE9;
            // RL10: pin low during internal reset
            rst_pin_oe  <= int_rst;
            rst_pin_out <= 1'b0;
            if (state_next == S_RES)
                cause_rst_reg <= 1'b1;
            else if (state_reg == S_HALT && state_next == S_STAB)
                cause_rst_reg <= 1'b0;
            else if (state_reg == S_RUN && state_next == S_STAB)
                cause_rst_reg <= 1'b0;
            // RL3: load 256 cycle delay
            if (state_next == S_STAB && state_reg != S_STAB)
                stab_reg <= `HMRS_STAB_CYC;
            else if (stab_reg != `HMRS_ZERO9)
                stab_reg <= stab_reg - `HMRS_ONE9;
            // RL4: resume by cause
            if (state_reg == S_STAB && state_next == S_RUN) begin
                fetch_reset_vector <= cause_rst_reg;
                // RL14: core pushes and masks
                service_wake_irq   <= ~cause_rst_reg;
            end
        end
    end

    // ==================================================
    // registers and sticky status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg      <= 3'h0;
            opt_reg       <= `HMRS_OPT_RST;
            stat_reg      <= 5'h00;
            mask_reg      <= 5'h00;
            lvd_threshold <= 2'h0;
        end else begin
            if (wr && paddr == `HMRS_OFF_CTRL)
                ctrl_reg <= pwdata[2:0];
            // RL13: threshold select
            if (wr && paddr == `HMRS_OFF_OPT)
                opt_reg <= pwdata[3:0];
            if (wr && paddr == `HMRS_OFF_MASK)
                mask_reg <= pwdata[`HMRS_ST_W-1:0];
            lvd_threshold <= opt_reg[`HMRS_OPT_THR_HI:`HMRS_OPT_THR_LO];
            // read clears only the bits already reported in prdata, new events win
            stat_reg <= ((rd && paddr == `HMRS_OFF_STAT) ?
                         (stat_reg & ~prdata[`HMRS_ST_W-1:0]) : stat_reg) |
                        {ill_rst, lvd_rst, wdg_rst,
                         (state_reg == S_HALT) & wake_src,
                         (state_reg == S_RUN) & (state_next == S_HALT)};
        end
    end

    // ==================================================
    // apb answer, single cycle access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_ok;
            irq     <= |(stat_reg & mask_reg);
            prdata  <= 32'h0000_0000;
            if (psel & ~penable & ~pwrite) begin
                case (paddr)
                    `HMRS_OFF_CTRL:  prdata <= {29'h0, ctrl_reg};
                    `HMRS_OFF_OPT:   prdata <= {28'h0, opt_reg};
                    `HMRS_OFF_STAT:  prdata <= {27'h0, stat_reg};
                    `HMRS_OFF_MASK:  prdata <= {27'h0, mask_reg};
                    `HMRS_OFF_STATE: prdata <= {28'h0, state_reg};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [tb/hmrs_pin_model.sv]
// Purpose: far side of the reset pin, board reset circuit
// Assumes: the pin has a pull-up
// Notes:   ext_hold stands for the board's reset circuit
`timescale 1ns/1ps
`default_nettype none
// ====
module hmrs_pin_model (
    input  wire logic ext_hold,
    input  wire logic rst_pin_oe,
    input  wire logic rst_pin_out,
    output wire logic rst_pin_in
);
    // board holds reset low
    // the pull-up wins when nobody drives the pin
    assign rst_pin_in = ext_hold ? 1'b0 : (rst_pin_oe ? rst_pin_out : 1'b1);
endmodule
`default_nettype wire

// [tb/hmrs_ctrl_monitor.sv]
// Purpose: port checker for the halt and reset controller
// Assumes: one clock, async low reset
// Notes:   attached by bind
`include "hmrs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
// ====
module hmrs_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       halt_instr,
    input wire logic       wdog_underflow,
    input wire logic       rst_pin_out,
    input wire logic       rst_pin_oe,
    input wire logic       osc_on,
    input wire logic       cpu_hold,
    input wire logic       fetch_reset_vector,
    input wire logic       service_wake_irq,
    input wire logic       clear_imask,
    input wire logic       sys_rst_n,
    input wire logic [1:0] lvd_threshold
);
    logic [4:0] wd_cnt;
    // cycles since the last watchdog underflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wd_cnt <= 5'h00;
        else if (wdog_underflow)
            wd_cnt <= 5'h01;
        else if (wd_cnt != 5'h00 && wd_cnt != 5'h1f)
            wd_cnt <= wd_cnt + 5'h01;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_wdog_pulse_width: assert property (
        wd_cnt != 5'h00 && wd_cnt < `HMRS_RSTOUT_CYC |-> rst_pin_oe) else $error("pin short");
    a_pin_open_drain: assert property (
        rst_pin_oe |-> !rst_pin_out) else $error("pin driven high");
    a_imask_on_halt: assert property (
        clear_imask |-> $past(halt_instr)) else $error("mask clear w/o halt");
    a_osc_holds_cpu: assert property (
        !osc_on |-> cpu_hold) else $error("cpu runs, osc off");
    a_stab_delay_len: assert property (
        $fell(cpu_hold) |-> $past(cpu_hold, 255)) else $error("stab too short");
    a_wake_resume_once: assert property (
        service_wake_irq |-> !fetch_reset_vector ##1 !service_wake_irq) else $error("bad wake");
    a_apb_ready_access: assert property (
        pready |-> psel && penable ##1 !pready) else $error("pready outside access");
    a_apb_err_ready: assert property (
        pslverr |-> pready) else $error("pslverr w/o pready");
    a_thr_by_write: assert property (
        !$stable(lvd_threshold) |-> $past(psel && penable && pwrite, 2) || !$past(sys_rst_n))
        else $error("threshold moved");
    c_wake: cover property (service_wake_irq);
    c_reset_fetch: cover property (fetch_reset_vector);
    c_err: cover property (pslverr);
endmodule
bind hmrs_ctrl hmrs_monitor hmrs_monitor_inst (.*);
`default_nettype wire

// [tb/halt_mode_and_reset_sources_test.sv]
// Purpose: apb driven test of halt, wake and reset sources
// Assumes: 40 MHz pclk, pin model supplies rst_pin_in
// Notes:   stab and reset outcomes timed from the design's outputs
`include "hmrs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
// ====
module halt_mode_and_reset_sources_test;
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic halt_instr, wake_irq, awu_irq, irq_pending, illegal_opcode, illegal_prebyte;
    logic wdog_underflow, lvd_below, ext_hold, rst_pin_in, rst_pin_out, rst_pin_oe;
    logic osc_on, cpu_hold, fetch_reset_vector, service_wake_irq, clear_imask, sys_rst_n, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  lvd_threshold;
    int fails = 0, samples_checked = 0, cyc = 0, n, k;
    hmrs_ctrl hmrs_ctrl_inst (.*);
    hmrs_pin_model hmrs_pin_model_inst (.*);
    // clock and hang limit
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 10000) begin
            fails++;
            end_sim;
        end
    end
    // ====
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic chb(input logic g, input logic x);
        chk({31'h0, g}, {31'h0, x});
    endtask
    task automatic wait_hi(ref logic s);
        n = 0;
        while (s !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic halt_pulse;
        @(posedge pclk) halt_instr <= 1'b1;
        @(posedge pclk) halt_instr <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ====
    initial begin
        {presetn, psel, penable, pwrite, halt_instr, wake_irq, awu_irq} = 7'h00;
        {irq_pending, illegal_opcode, illegal_prebyte, wdog_underflow, lvd_below} = 5'h00;
        {ext_hold, paddr, pwdata} = {1'b1, 8'h00, 32'h0};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        chb(sys_rst_n, 1'b0);
        ext_hold <= 1'b0;
        wait_hi(fetch_reset_vector);
        apb(`HMRS_OFF_STATE, 1'b0, 32'h0);
        chk(q, 32'h1);
        apb(8'h20, 1'b0, 32'h0);
        chb(e, 1'b1);
        apb(`HMRS_OFF_OPT, 1'b1, 32'hb);
        apb(`HMRS_OFF_MASK, 1'b1, 32'h1f);
        chk({30'h0, lvd_threshold}, 32'h2);
        for (k = 0; k < 2; k++) begin
            apb(`HMRS_OFF_CTRL, 1'b1, 32'(k));
            halt_pulse;
            @(posedge pclk);
            chb(osc_on, 1'b0);
            apb(`HMRS_OFF_STATE, 1'b0, 32'h0);
            chk(q, 32'h2);
            chb(irq, 1'b1);
            if (k == 1) awu_irq <= 1'b1;
            else wake_irq <= 1'b1;
            wait_hi(service_wake_irq);
            chb(n >= 256 && n < 262, 1'b1);
            {wake_irq, awu_irq} <= 2'h0;
            apb(`HMRS_OFF_STAT, 1'b0, 32'h0);
            chk(q, 32'h3);
            apb(`HMRS_OFF_STAT, 1'b0, 32'h0);
            repeat (2) @(posedge pclk);
            chk({q[31:1], irq}, 32'h0);
        end
        irq_pending <= 1'b1;
        halt_pulse;
        apb(`HMRS_OFF_STATE, 1'b0, 32'h0);
        chk(q, 32'h4);
        wait_hi(service_wake_irq);
        irq_pending <= 1'b0;
        for (k = 0; k < 4; k++) begin
            apb(`HMRS_OFF_OPT, 1'b1, 32'hb);
            @(posedge pclk);
            {wdog_underflow, illegal_opcode, illegal_prebyte, lvd_below} <= 4'h8 >> k;
            @(posedge pclk);
            {wdog_underflow, illegal_opcode, illegal_prebyte} <= 3'h0;
            @(posedge pclk);
            chb(sys_rst_n, 1'b0);
            repeat (2) @(posedge pclk);
            chb(rst_pin_oe, k != 1 && k != 2);
            repeat (30) @(posedge pclk);
            lvd_below <= 1'b0;
            wait_hi(fetch_reset_vector);
            apb(`HMRS_OFF_STAT, 1'b0, 32'h0);
            chk({29'h0, q[4:2]}, k == 0 ? 32'h1 : (k == 3 ? 32'h2 : 32'h4));
        end
        apb(`HMRS_OFF_OPT, 1'b1, 32'h2);
        lvd_below <= 1'b1;
        repeat (5) @(posedge pclk);
        chb(sys_rst_n & ~rst_pin_oe, 1'b1);
        lvd_below <= 1'b0;
        apb(`HMRS_OFF_OPT, 1'b1, 32'h8);
        apb(`HMRS_OFF_CTRL, 1'b1, 32'h4);
        halt_pulse;
        repeat (3) @(posedge pclk);
        chb(sys_rst_n, 1'b0);
        wait_hi(fetch_reset_vector);
        end_sim;
    end
endmodule
`default_nettype wire
